// ==== verilog/can_mode_buffer.sv ====
// The plain strobed port and the address map were left to the implementer.
`timescale 1ns/1ps
`include "can_map.svh"
// Behaviour
// - disabled mode sends and receives nothing; wake may set; flags, counters kept.
// - disable request waits 11 recessive bits, then current mode shows 001.
// - config bit 14 enables low-pass filter on receive pin while asleep.
// - new transmit waits 11 recessive bits; disable meanwhile aborts pending.
// - mode 000 drives the bus pins and sends and receives frames.
// - listen-only is passive: no error flags, no ack, counters frozen.
// - mode 111 ignores errors, stores every frame, even errored ones.
// - loopback ties internal transmit to internal receive, pins released.
// - 32 buffers, size field 15:13, first 8 receive unless transmit-enabled.
// - stored frame sets receive-buffer flag bit 1, software clears it.
// - pointer 1111 stores into next FIFO slot between start and size.
// - each filter has a 4-bit pointer to one of buffers 0 to 14, or 1111 for the FIFO.
// - frame extension bit selects which filters are compared.
// - zero mask bit always matches; filter picks one of three masks, or with select 11 an all-ones mask for an exact match.
// - receive errors bump the counter; warning flag bit 9 at 96.
// - receive flag set after a stored frame; wake flag on wakeup.
// - summary error flag, invalid flag, overrun bit 2, passive above 127.
// - up to eight buffers transmit when their transmit-enable bit is set.
// - priority 11 highest, 00 lowest; ties go to higher buffer index.
// - setting request clears abort, lost and error flags; best sent when idle.
// - success clears the request and flags a transmit interrupt if enabled.
// - failure keeps the request; error flag on error, lost flag on arbitration.
// - mode changes and current-mode update wait for an idle bus, except when leaving disable mode.
module can_mode_buffer
  import can_pkg::*;
#(
  parameter int FILTERS    = 16,
  parameter int TX_BUFFERS = 8
)(
  input  wire logic           clock,
  input  wire logic           sys_rst,
  input  wire logic [7:0]     reg_addr,
  input  wire logic [15:0]    reg_wdata,
  input  wire logic           reg_write,
  input  wire logic           reg_read,
  output logic [15:0]         reg_rdata,
  input  wire engine_in_type  engine_in,
  output engine_out_type      engine_out,
  input  wire logic           bus_receive_pin,
  output logic                bus_transmit_pin,
  output logic                bus_transmit_oe,
  output logic                bus_pins_owned,
  output logic                irq
);
  localparam int WAKE_CYC = `WAKE_FILTER_CYC;

  logic [2:0]  req_mode_q, cur_mode_q;
  logic [15:0] cfg2_q, fctrl_q, intf_q, inte_q, fen_q;
  logic [7:0]  rx_cnt_q;
  logic [31:0] rxful_q;
  logic [4:0]  fifo_ptr_q;
  logic [3:0]  idle_cnt_q;
  logic [7:0]  wake_cnt_q;
  logic [TX_BUFFERS-1:0] txen_q, treq_q, tabt_q, tlarb_q, terr_q, tie_q;
  logic [TX_BUFFERS-1:0][1:0] tpri_q;
  logic [FILTERS-1:0][3:0]    bptr_q;
  logic [FILTERS-1:0][1:0]    msel_q;
  logic [FILTERS-1:0][28:0]   fid_q;
  logic [FILTERS-1:0]         fext_q, hit;
  logic [2:0][28:0]           mask_q;
  tx_state_type tx_state_q;
  logic [2:0]   tx_cur_q;

  logic        rx_int, bus_idle, change_ok, wake_ev, rx_mode, count_mode;
  logic        tx_mode, found, start, hit_any, store, is_fifo, frame_ev;
  logic [2:0]  best_idx;
  logic [3:0]  hit_ptr;
  logic [4:0]  dest, fifo_end;
  logic [15:0] intf_set, rdata_d;
  logic [7:0]  rx_cnt_next;

  // loopback feeds the engine its own transmit bit, never the pin
  assign rx_int = (cur_mode_q == `MODE_LOOPBACK) ? engine_in.tx_bit
                                                 : bus_receive_pin;
  assign bus_idle  = (idle_cnt_q == `IDLE_BITS);
  assign change_ok = (cur_mode_q == `MODE_DISABLE) || bus_idle;
  assign rx_mode   = (cur_mode_q != `MODE_DISABLE)
                     && (cur_mode_q != `MODE_CONFIG);
  assign tx_mode   = (cur_mode_q == `MODE_NORMAL)
                     || (cur_mode_q == `MODE_LOOPBACK);
  assign count_mode = tx_mode;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cur_mode_q <= `MODE_RESET;
    end else if (req_mode_q != cur_mode_q && change_ok
                 && tx_state_q == TX_IDLE) begin
      cur_mode_q <= req_mode_q;
    end
  end

  // count restarts on any mode change so a fresh mode sees 11 idle bits
  always_ff @(posedge clock) begin
    if (sys_rst || cur_mode_q != req_mode_q && change_ok) begin
      idle_cnt_q <= 4'h0;
    end else if (engine_in.bit_valid) begin
      if (!rx_int) begin
        idle_cnt_q <= 4'h0;
      end else if (!bus_idle) begin
        idle_cnt_q <= idle_cnt_q + 4'h1;
      end
    end
  end

  // the filter trades wake latency for immunity to glitches
  always_ff @(posedge clock) begin
    if (sys_rst || bus_receive_pin) begin
      wake_cnt_q <= 8'h00;
    end else if (wake_cnt_q != 8'hFF) begin
      wake_cnt_q <= wake_cnt_q + 8'h01;
    end
  end
  assign wake_ev = (cur_mode_q == `MODE_DISABLE) && !bus_receive_pin
                   && (!cfg2_q[`CFG2_WAKE_FILTER_ENABLE]
                       || wake_cnt_q >= 8'(WAKE_CYC - 1));

  genvar g;
  generate
    for (g = 0; g < FILTERS; g++) begin : gen_flt
      acceptance_filter u_flt (
        .enable                 (fen_q[g]),
        .filter_id              (fid_q[g]),
        .filter_extended_select (fext_q[g]),
        .mask_id                ((msel_q[g] == 2'h3) ? {29{1'b1}}
                                 : mask_q[msel_q[g]]),
        .frame_id               (engine_in.frame_id),
        .frame_ide              (engine_in.frame_ide),
        .hit                    (hit[g])
      );
    end
  endgenerate

  always_comb begin
    case (fctrl_q[15:13])
      3'h0:    fifo_end = 5'h03;
      3'h1:    fifo_end = 5'h05;
      3'h2:    fifo_end = 5'h07;
      3'h3:    fifo_end = 5'h0B;
      3'h4:    fifo_end = 5'h0F;
      3'h5:    fifo_end = 5'h17;
      default: fifo_end = 5'h1F;
    endcase
  end

  always_comb begin
    hit_any = 1'b0;
    hit_ptr = 4'h0;
    for (int i = FILTERS - 1; i >= 0; i--) begin
      if (hit[i]) begin
        hit_any = 1'b1;
        hit_ptr = bptr_q[i];
      end
    end
    frame_ev = engine_in.frame_done
               || (cur_mode_q == `MODE_LISTEN_ALL && engine_in.rx_error);
    is_fifo = !hit_any || hit_ptr == `FIFO_CODE;
    dest    = is_fifo ? fifo_ptr_q : {1'b0, hit_ptr};
    // a low buffer turned to transmit is never overwritten by reception
    store   = rx_mode && frame_ev
              && (hit_any || cur_mode_q == `MODE_LISTEN_ALL)
              && !(dest < 5'h08 && txen_q[dest[2:0]]);
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      fifo_ptr_q <= 5'h00;
    end else if (reg_write && reg_addr == `A_FCTRL) begin
      fifo_ptr_q <= reg_wdata[4:0];
    end else if (store && is_fifo) begin
      fifo_ptr_q <= (fifo_ptr_q >= fifo_end) ? fctrl_q[4:0]
                                             : fifo_ptr_q + 5'h01;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rxful_q <= 32'h00000000;
    end else begin
      if (reg_write && reg_addr == `A_RXFUL1) begin
        rxful_q[15:0] <= rxful_q[15:0] & reg_wdata;
      end
      if (reg_write && reg_addr == `A_RXFUL2) begin
        rxful_q[31:16] <= rxful_q[31:16] & reg_wdata;
      end
      if (store) begin
        rxful_q[dest] <= 1'b1;
      end
    end
  end

  assign rx_cnt_next = (rx_cnt_q == `COUNT_MAX) ? rx_cnt_q
                                                : rx_cnt_q + 8'h01;
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rx_cnt_q <= 8'h00;
    end else if (count_mode && engine_in.rx_error) begin
      rx_cnt_q <= rx_cnt_next;
    end
  end

  always_comb begin
    intf_set = 16'h0000;
    intf_set[`I_RB]   = store;
    intf_set[`I_RBOV] = store && rxful_q[dest];
    intf_set[`I_WAKE] = wake_ev;
    intf_set[`I_IVR]  = rx_mode && engine_in.rx_error;
    intf_set[`I_RECEIVE_WARNING_FLAG] = count_mode && engine_in.rx_error
                         && rx_cnt_next == `WARN_LIMIT;
    intf_set[`I_TX]   = tx_state_q == TX_ACTIVE && engine_in.tx_ok
                        && tie_q[tx_cur_q];
    intf_set[`I_ERR]  = intf_set[`I_RBOV] || intf_set[`I_IVR]
                        || intf_set[`I_RECEIVE_WARNING_FLAG]
                        || (tx_state_q == TX_ACTIVE && engine_in.tx_error
                            && tie_q[tx_cur_q]);
  end

  // write zero clears; a set in the same cycle still wins
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      intf_q <= 16'h0000;
    end else if (reg_write && reg_addr == `A_INTF) begin
      intf_q <= (intf_q & reg_wdata) | intf_set;
    end else begin
      intf_q <= intf_q | intf_set;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      req_mode_q <= `MODE_RESET;
      cfg2_q     <= 16'h0000;
      fctrl_q    <= 16'h0000;
      inte_q     <= 16'h0000;
      fen_q      <= 16'h0000;
    end else if (reg_write) begin
      case (reg_addr)
        `A_CTRL:  req_mode_q <= reg_wdata[10:8];
        `A_CFG2:  cfg2_q     <= reg_wdata;
        `A_FCTRL: fctrl_q    <= reg_wdata;
        `A_INTE:  inte_q     <= reg_wdata;
        `A_FEN:   fen_q      <= reg_wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      bptr_q <= '0;
      msel_q <= '0;
      mask_q <= '0;
      fid_q  <= '0;
      fext_q <= '0;
    end else if (reg_write) begin
      for (int i = 0; i < FILTERS; i++) begin
        if ((reg_addr & 8'hFC) == `A_BPTR && reg_addr[1:0] == 2'(i / 4)) begin
          bptr_q[i] <= reg_wdata[4 * (i % 4) +: 4];
        end
        if ((reg_addr & 8'hFE) == `A_MSEL && reg_addr[0] == 1'(i / 8)) begin
          msel_q[i] <= reg_wdata[2 * (i % 8) +: 2];
        end
        if ((reg_addr & 8'hE0) == `A_FLT && reg_addr[4:1] == 4'(i)) begin
          if (reg_addr[0]) begin
            fid_q[i][15:0] <= reg_wdata;
          end else begin
            fid_q[i][28:16] <= {reg_wdata[15:5], reg_wdata[1:0]};
            fext_q[i]       <= reg_wdata[3];
          end
        end
      end
      for (int m = 0; m < 3; m++) begin
        if ((reg_addr & 8'hFE) == `A_MASK + 8'(2 * m)) begin
          if (reg_addr[0]) begin
            mask_q[m][15:0] <= reg_wdata;
          end else begin
            mask_q[m][28:16] <= {reg_wdata[15:5], reg_wdata[1:0]};
          end
        end
      end
    end
  end

  tx_arbiter #(.BUFFERS(TX_BUFFERS)) u_arb (
    .pending        (treq_q & txen_q),
    .priority_field (tpri_q),
    .found          (found),
    .index          (best_idx)
  );

  // the winner is picked at start time, so late priority edits still count
  assign start = tx_state_q == TX_IDLE && tx_mode && bus_idle
                 && found && req_mode_q == cur_mode_q;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      tx_state_q <= TX_IDLE;
      tx_cur_q   <= 3'h0;
    end else begin
      case (tx_state_q)
        TX_IDLE: begin
          if (start) begin
            tx_state_q <= TX_ACTIVE;
            tx_cur_q   <= best_idx;
          end
        end
        TX_ACTIVE: begin
          if (engine_in.tx_ok || engine_in.tx_error || engine_in.tx_lost) begin
            tx_state_q <= TX_IDLE;
          end
        end
        default: tx_state_q <= TX_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      txen_q  <= '0;
      treq_q  <= '0;
      tabt_q  <= '0;
      tlarb_q <= '0;
      terr_q  <= '0;
      tie_q   <= '0;
      tpri_q  <= '0;
    end else begin
      for (int b = 0; b < TX_BUFFERS; b++) begin
        if ((reg_addr & 8'hFC) == `A_TRCON && reg_write
            && reg_addr[1:0] == 2'(b / 2)) begin
          txen_q[b] <= reg_wdata[8 * (b % 2) + `T_TXEN];
          tie_q[b]  <= reg_wdata[8 * (b % 2) + `T_IE];
          tpri_q[b] <= reg_wdata[8 * (b % 2) +: 2];
          treq_q[b] <= reg_wdata[8 * (b % 2) + `T_REQ];
          if (reg_wdata[8 * (b % 2) + `T_REQ]) begin
            tabt_q[b]  <= 1'b0;
            tlarb_q[b] <= 1'b0;
            terr_q[b]  <= 1'b0;
          end
        end
        if (tx_state_q == TX_IDLE && req_mode_q == `MODE_DISABLE
            && cur_mode_q != `MODE_DISABLE && treq_q[b]) begin
          treq_q[b] <= 1'b0;
          tabt_q[b] <= 1'b1;
        end
      end
      if (tx_state_q == TX_ACTIVE) begin
        if (engine_in.tx_ok) begin
          treq_q[tx_cur_q] <= 1'b0;
        end
        if (engine_in.tx_error) begin
          terr_q[tx_cur_q] <= 1'b1;
        end
        if (engine_in.tx_lost) begin
          tlarb_q[tx_cur_q] <= 1'b1;
        end
      end
    end
  end

  always_comb begin
    rdata_d = 16'h0000;
    case (reg_addr)
      `A_CTRL:   rdata_d = {5'h00, req_mode_q, cur_mode_q, 5'h00};
      `A_CFG2:   rdata_d = cfg2_q;
      `A_FCTRL:  rdata_d = fctrl_q;
      `A_INTF:   rdata_d = intf_q
                           | {4'h0, rx_cnt_q > `PASSIVE_LIMIT, 11'h000};
      `A_INTE:   rdata_d = inte_q;
      `A_ERRCNT: rdata_d = {8'h00, rx_cnt_q};
      `A_RXFUL1: rdata_d = rxful_q[15:0];
      `A_RXFUL2: rdata_d = rxful_q[31:16];
      `A_FEN:    rdata_d = fen_q;
      default: begin
        for (int b = 0; b < TX_BUFFERS; b++) begin
          if ((reg_addr & 8'hFC) == `A_TRCON && reg_addr[1:0] == 2'(b / 2)) begin
            rdata_d[8 * (b % 2) +: 8] = {txen_q[b], tabt_q[b], tlarb_q[b],
                                         terr_q[b], treq_q[b], tie_q[b],
                                         tpri_q[b]};
          end
        end
        for (int i = 0; i < FILTERS; i++) begin
          if ((reg_addr & 8'hFC) == `A_BPTR && reg_addr[1:0] == 2'(i / 4)) begin
            rdata_d[4 * (i % 4) +: 4] = bptr_q[i];
          end
          if ((reg_addr & 8'hFE) == `A_MSEL && reg_addr[0] == 1'(i / 8)) begin
            rdata_d[2 * (i % 8) +: 2] = msel_q[i];
          end
          if ((reg_addr & 8'hE0) == `A_FLT && reg_addr[4:1] == 4'(i)) begin
            rdata_d = reg_addr[0] ? fid_q[i][15:0]
                      : {fid_q[i][28:18], 1'b0, fext_q[i], 1'b0,
                         fid_q[i][17:16]};
          end
        end
        for (int m = 0; m < 3; m++) begin
          if ((reg_addr & 8'hFE) == `A_MASK + 8'(2 * m)) begin
            rdata_d = reg_addr[0] ? mask_q[m][15:0]
                      : {mask_q[m][28:18], 3'h0, mask_q[m][17:16]};
          end
        end
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_read) begin
      reg_rdata <= rdata_d;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      engine_out       <= '0;
      engine_out.rx_bit <= 1'b1;
      bus_transmit_pin <= 1'b1;
      bus_transmit_oe  <= 1'b0;
      bus_pins_owned   <= 1'b0;
      irq              <= 1'b0;
    end else begin
      engine_out.rx_bit        <= rx_int;
      engine_out.passive       <= cur_mode_q == `MODE_LISTEN_ONLY;
      engine_out.ignore_errors <= cur_mode_q == `MODE_LISTEN_ALL;
      engine_out.tx_start      <= start;
      engine_out.tx_index      <= best_idx;
      engine_out.store_valid   <= store;
      engine_out.store_index   <= dest;
      bus_transmit_oe  <= cur_mode_q == `MODE_NORMAL;
      bus_transmit_pin <= (cur_mode_q == `MODE_NORMAL) ? engine_in.tx_bit
                                                        : 1'b1;
      bus_pins_owned   <= rx_mode && cur_mode_q != `MODE_LOOPBACK;
      irq              <= |(intf_q & inte_q);
    end
  end
endmodule

// ==== common/can_map.svh ====
`ifndef CAN_MAP_SVH
`define CAN_MAP_SVH

`define MODE_NORMAL      3'h0
`define MODE_DISABLE     3'h1
`define MODE_LOOPBACK    3'h2
`define MODE_LISTEN_ONLY 3'h3
`define MODE_CONFIG      3'h4
`define MODE_LISTEN_ALL  3'h7
`define MODE_RESET       3'h4

`define IDLE_BITS        4'hB
`define FIFO_CODE        4'hF
`define WARN_LIMIT       8'h60
`define PASSIVE_LIMIT    8'h7F
`define COUNT_MAX        8'hFF

`define CLOCK_MHZ        20
`define WAKE_FILTER_NS   500
`define WAKE_FILTER_CYC  ((`WAKE_FILTER_NS * `CLOCK_MHZ + 999) / 1000)

`define A_CTRL   8'h00
`define A_CFG2   8'h01
`define A_FCTRL  8'h02
`define A_INTF   8'h03
`define A_INTE   8'h04
`define A_ERRCNT 8'h05
`define A_RXFUL1 8'h06
`define A_RXFUL2 8'h07
`define A_TRCON  8'h08
`define A_FEN    8'h0C
`define A_BPTR   8'h10
`define A_MSEL   8'h14
`define A_MASK   8'h18
`define A_FLT    8'h20

`define CTRL_REQ_LSB   8
`define CTRL_CUR_LSB   5
`define CFG2_WAKE_FILTER_ENABLE    14
`define FCTRL_SIZE_LSB 13

`define I_TX    0
`define I_RB    1
`define I_RBOV  2
`define I_WAKE  3
`define I_ERR   5
`define I_IVR   7
`define I_RECEIVE_WARNING_FLAG 9
`define I_RECEIVE_ERROR_PASSIVE_FLAG  11

`define T_TXEN 7
`define T_ABT  6
`define T_LARB 5
`define T_ERR  4
`define T_REQ  3
`define T_IE   2

`endif

// ==== common/can_pkg.sv ====
package can_pkg;

  typedef struct packed {
    logic        bit_valid;
    logic        tx_bit;
    logic        frame_done;
    logic [28:0] frame_id;
    logic        frame_ide;
    logic        rx_error;
    logic        tx_ok;
    logic        tx_error;
    logic        tx_lost;
  } engine_in_type;

  typedef struct packed {
    logic       rx_bit;
    logic       passive;
    logic       ignore_errors;
    logic       tx_start;
    logic [2:0] tx_index;
    logic       store_valid;
    logic [4:0] store_index;
  } engine_out_type;

  typedef enum logic {TX_IDLE, TX_ACTIVE} tx_state_type;

endpackage

// ==== verilog/acceptance_filter.sv ====
`timescale 1ns/1ps
module acceptance_filter (
  input  wire logic        enable,
  input  wire logic [28:0] filter_id,
  input  wire logic        filter_extended_select,
  input  wire logic [28:0] mask_id,
  input  wire logic [28:0] frame_id,
  input  wire logic        frame_ide,
  output logic             hit
);
  logic [28:0] care;

  always_comb begin
    // standard frames carry no extension bits, so those never take part
    care = frame_ide ? mask_id : {mask_id[28:18], 18'h00000};
    hit  = enable && (filter_extended_select == frame_ide)
           && (((frame_id ^ filter_id) & care) == 29'h00000000);
  end
endmodule

// ==== verilog/tx_arbiter.sv ====
`timescale 1ns/1ps
module tx_arbiter #(
  parameter int BUFFERS = 8
)(
  input  wire logic [BUFFERS-1:0]      pending,
  input  wire logic [BUFFERS-1:0][1:0] priority_field,
  output logic                         found,
  output logic [$clog2(BUFFERS)-1:0]   index
);
  logic [1:0] best;

  always_comb begin
    found = 1'b0;
    index = '0;
    best  = 2'h0;
    // ascending scan with >= lets the higher index win a tie
    for (int i = 0; i < BUFFERS; i++) begin
      if (pending[i] && (!found || priority_field[i] >= best)) begin
        found = 1'b1;
        best  = priority_field[i];
        index = i[$clog2(BUFFERS)-1:0];
      end
    end
  end
endmodule

// ==== sim/can_mode_buffer_checker.sv ====
`timescale 1ns/1ps
module can_mode_buffer_checker
  import can_pkg::*;
#(
  parameter int FILTERS    = 16,
  parameter int TX_BUFFERS = 8
)(
  input wire logic           clock,
  input wire logic           sys_rst,
  input wire logic [7:0]     reg_addr,
  input wire logic [15:0]    reg_wdata,
  input wire logic           reg_write,
  input wire logic           reg_read,
  input wire logic [15:0]    reg_rdata,
  input wire engine_in_type  engine_in,
  input wire engine_out_type engine_out,
  input wire logic           bus_receive_pin,
  input wire logic           bus_transmit_pin,
  input wire logic           bus_transmit_oe,
  input wire logic           bus_pins_owned,
  input wire logic           irq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  sequence s_start;
    engine_out.tx_start;
  endsequence
  // two cycles of drive so the registered pin has settled on tx_bit
  sequence s_driving;
    bus_transmit_oe && $past(bus_transmit_oe);
  endsequence
  a_start_one_cycle:
    assert property (s_start |=> !engine_out.tx_start)
    else $error("transmit start held too long");
  a_store_has_cause:
    assert property (engine_out.store_valid |->
      $past(engine_in.frame_done || engine_in.rx_error))
    else $error("store without a finished frame");
  a_drive_follows:
    assert property (s_driving |-> bus_transmit_pin == $past(engine_in.tx_bit))
    else $error("driven pin does not follow engine bit");
  a_release_high:
    assert property (!bus_transmit_oe |-> bus_transmit_pin)
    else $error("released transmit pin not recessive");
  a_oe_owns_pins:
    assert property (bus_transmit_oe |-> bus_pins_owned)
    else $error("driving without owning the pins");
  a_passive_quiet:
    assert property (engine_out.passive |->
      !bus_transmit_oe && !engine_out.tx_start)
    else $error("passive mode touches the bus");
  a_listen_all_rx:
    assert property (engine_out.ignore_errors |->
      !bus_transmit_oe && !engine_out.passive)
    else $error("listen-all mode drives or is passive");
  a_rx_from_pin:
    assert property (bus_pins_owned && $past(bus_pins_owned) |->
      engine_out.rx_bit == $past(bus_receive_pin))
    else $error("receive level not taken from pin");
endmodule

bind can_mode_buffer can_mode_buffer_checker #(
  .FILTERS(FILTERS), .TX_BUFFERS(TX_BUFFERS)) can_mode_buffer_checker_i (.*);

// ==== sim/can_engine_model.sv ====
`timescale 1ns/1ps
module can_engine_model
  import can_pkg::*;
(
  input  wire logic           clock,
  input  wire logic           bits_on,
  input  wire logic           dominant,
  input  wire logic           slow,
  input  wire logic [1:0]     result,
  input  wire logic           done_req,
  input  wire logic           err_req,
  input  wire logic [28:0]    id,
  input  wire logic           ide,
  input  wire engine_out_type engine_out,
  input  wire logic           bus_transmit_pin,
  input  wire logic           bus_transmit_oe,
  output engine_in_type       engine_in,
  output logic                bus_receive_pin
);
  logic [1:0] div_q = 2'h0;
  int         wait_q = 0;
  initial engine_in = '0;
  // wired-and bus: other nodes or our own driver pull it dominant
  assign bus_receive_pin = !dominant && (!bus_transmit_oe || bus_transmit_pin);
  always @(posedge clock) begin
    div_q <= div_q + 2'h1;
    engine_in.bit_valid <= bits_on && div_q == 2'h3;
    engine_in.tx_bit <= 1'b1;
    engine_in.frame_done <= done_req;
    engine_in.frame_id <= id;
    engine_in.frame_ide <= ide;
    engine_in.rx_error <= err_req;
    // one verdict per attempt for result 0 to 2, none for 3, after a short or long frame time
    if (engine_out.tx_start === 1'b1)
      wait_q <= slow ? 12 : 1;
    else if (wait_q > 0)
      wait_q <= wait_q - 1;
    engine_in.tx_ok <= wait_q == 1 && result == 2'h0;
    engine_in.tx_error <= wait_q == 1 && result == 2'h1;
    engine_in.tx_lost <= wait_q == 1 && result == 2'h2;
  end
endmodule

// ==== sim/tb_can_mode_buffer.sv ====
`timescale 1ns/1ps
`include "can_map.svh"
module tb_can_mode_buffer
  import can_pkg::*;
;
  localparam logic [28:0] hit_id = 29'h0A940000;
  logic           clock = 1'b0;
  logic           sys_rst = 1'b1;
  logic [7:0]     reg_addr = 8'h00;
  logic [15:0]    reg_wdata = 16'h0000;
  logic           reg_write = 1'b0;
  logic           reg_read = 1'b0;
  logic [15:0]    reg_rdata, d;
  engine_in_type  engine_in;
  engine_out_type engine_out;
  logic           bus_receive_pin, bus_transmit_pin, bus_transmit_oe;
  logic           bus_pins_owned, irq, done_req = 1'b0, err_req = 1'b0;
  logic           bits_on = 1'b1, dominant = 1'b0, slow = 1'b1, ide = 1'b0;
  logic [1:0]     result = 2'h0;
  logic [28:0]    id = 29'h0;
  logic [2:0]     m[4] = '{3'h3, 3'h7, 3'h2, 3'h0};
  logic [15:0]    txq[$], stq[$], e[$];
  int             n_errors = 0, check_count = 0, pri[8];
  bit             pend[8];

  can_mode_buffer #(.FILTERS(16), .TX_BUFFERS(8)) can_mode_buffer_i (.*);
  can_engine_model can_engine_model_i (.*);

  always #25 clock = !clock;
  always @(posedge clock) begin
    if (engine_out.tx_start === 1'b1)
      txq.push_back(16'(engine_out.tx_index));
    if (engine_out.store_valid === 1'b1)
      stq.push_back(16'(engine_out.store_index));
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chkq(input logic [15:0] g[$], input logic [15:0] x[$]);
    chk(16'(g.size()), 16'(x.size()));
    foreach (x[k]) chk(g[k], x[k]);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic send(input logic [28:0] i, input logic x, input logic er);
    @(posedge clock);
    id <= i;
    ide <= x;
    done_req <= !er;
    err_req <= er;
    @(posedge clock);
    done_req <= 1'b0;
    err_req <= 1'b0;
    repeat (4) @(posedge clock);
  endtask
  task automatic bits(input int n);
    repeat (n) @(posedge clock iff engine_in.bit_valid);
  endtask
  // highest priority wins; ties go to the higher index
  function automatic int best();
    int b;
    b = -1;
    for (int k = 0; k < 8; k++)
      if (pend[k] && (b < 0 || pri[k] >= pri[b])) b = k;
    return b;
  endfunction
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // whole run needs about 1200 cycles
  initial begin
    repeat (20000) @(posedge clock);
    n_errors++;
    stop_test();
  end

  initial begin
    void'($urandom(57950));
    repeat (16) @(posedge clock);
    sys_rst <= 1'b0;
    rd(`A_CTRL);
    chk(d & 16'h07E0, 16'h0480);
    // hold the bus busy so the idle count starts from a known bit
    dominant <= 1'b1;
    wr(`A_CTRL, 16'h0000);
    bits(1);
    dominant <= 1'b0;
    bits(10);
    rd(`A_CTRL);
    chk(d & 16'h07E0, 16'h0080);
    bits(2);
    rd(`A_CTRL);
    chk(d & 16'h07E0, 16'h0000);
    chk({14'h0, bus_pins_owned, bus_transmit_oe}, 16'h0003);
    $display("mode entry test done");
    wr(`A_FLT, 16'h54A0);
    wr(`A_MSEL, 16'h0003);
    wr(`A_BPTR, 16'h0005);
    wr(`A_FEN, 16'h0001);
    wr(`A_INTE, 16'h0002);
    send(hit_id, 1'b0, 1'b0);
    send(hit_id, 1'b1, 1'b0);
    chkq(stq, '{16'h5});
    rd(`A_INTF);
    chk(d & 16'h0006, 16'h0002);
    chk({15'h0, irq}, 16'h0001);
    send(hit_id, 1'b0, 1'b0);
    rd(`A_INTF);
    chk(d & 16'h0004, 16'h0004);
    stq.delete();
    wr(`A_RXFUL1, 16'h0000);
    wr(`A_MASK, 16'h0000);
    wr(`A_MASK + 8'h01, 16'h0000);
    wr(`A_MSEL, 16'h0000);
    send({11'($urandom), 18'h0}, 1'b0, 1'b0);
    wr(`A_BPTR, 16'h000F);
    wr(`A_FCTRL, 16'h4006);
    repeat (2) send(29'($urandom) & 29'h1FFC0000, 1'b0, 1'b0);
    chkq(stq, '{16'h5, 16'h6, 16'h7});
    $display("receive test done");
    repeat (95) send(29'h0, 1'b0, 1'b1);
    rd(`A_INTF);
    chk(d & 16'h0200, 16'h0000);
    send(29'h0, 1'b0, 1'b1);
    rd(`A_INTF);
    chk(d & 16'h0200, 16'h0200);
    $display("error count test done");
    dominant <= 1'b1;
    result <= 2'h2;
    bits(1);
    wr(`A_TRCON, 16'h8F8C);
    wr(`A_TRCON + 8'h01, 16'h008F);
    dominant <= 1'b0;
    for (int t = 0; t < 400 && !engine_in.tx_lost; t++) @(posedge clock);
    result <= 2'h0;
    for (int t = 0; t < 900 && txq.size() < 4; t++) @(posedge clock);
    repeat (20) @(posedge clock);
    pri = '{0, 3, 3, 0, 0, 0, 0, 0};
    pend = '{1, 1, 1, 0, 0, 0, 0, 0};
    e = {16'(best())};
    repeat (3) begin
      e.push_back(16'(best()));
      pend[e[$]] = 1'b0;
    end
    chkq(txq, e);
    rd(`A_TRCON);
    chk(d, 16'h8784);
    rd(`A_TRCON + 8'h01);
    chk(d & 16'h00FF, 16'h00A7);
    $display("transmit test done");
    foreach (m[k]) begin
      wr(`A_CTRL, {5'h0, m[k], 8'h00});
      bits(12);
      rd(`A_CTRL);
      chk(d & 16'h07E0, {5'h0, m[k], m[k], 5'h0});
    end
    $display("mode table test done");
    dominant <= 1'b1;
    bits(1);
    wr(`A_TRCON, 16'h878C);
    wr(`A_TRCON + 8'h01, 16'h008F);
    wr(`A_CTRL, 16'h0100);
    dominant <= 1'b0;
    bits(12);
    rd(`A_CTRL);
    chk(d & 16'h07E0, 16'h0120);
    chk({14'h0, bus_pins_owned, bus_transmit_oe}, 16'h0000);
    rd(`A_TRCON);
    chk(d, 16'h87C4);
    rd(`A_TRCON + 8'h01);
    chk(d & 16'h00FF, 16'h00C7);
    dominant <= 1'b1;
    send(hit_id, 1'b0, 1'b0);
    rd(`A_ERRCNT);
    chk(d, 16'h0060);
    chk(16'(stq.size() + txq.size()), 16'h0007);
    rd(`A_INTF);
    chk(d & 16'h0008, 16'h0008);
    $display("disable test done");
    stop_test();
  end
endmodule
